/* File: logic/bdm_pkg.sv */
package bdm_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned BDM_DATA_W = 8;   // Register width
  localparam int unsigned BDM_ADDR_W = 7;   // Direct address field width
  localparam int unsigned BDM_FADDR_W = 8;  // Full banked file address width

  // ----------------------------------------------------------------
  // Core register offsets (low seven bits, same in both banks)
  // ----------------------------------------------------------------
  localparam logic [6:0] BDM_OFS_INDIRECT = 7'h00;
  localparam logic [6:0] BDM_OFS_PCL = 7'h02;
  localparam logic [6:0] BDM_OFS_STATUS = 7'h03;
  localparam logic [6:0] BDM_OFS_FSR = 7'h04;
  localparam logic [6:0] BDM_OFS_PROGRAM_COUNTER_UPPER_LATCH = 7'h0A;
  localparam logic [6:0] BDM_OFS_INTCTL = 7'h0B;

  // ----------------------------------------------------------------
  // Map boundaries
  // ----------------------------------------------------------------
  localparam logic [7:0] BDM_SLOT_LIMIT = 8'h20;     // Slots below this offset
  localparam logic [7:0] BDM_B0_RAM_LO = 8'h20;
  localparam logic [7:0] BDM_B0_RAM_HI = 8'h7F;
  localparam logic [7:0] BDM_B1_RAM_LO = 8'hA0;
  localparam logic [7:0] BDM_B1_RAM_HI = 8'hBF;
  localparam logic [7:0] BDM_B1_SHARE_LO = 8'hF0;
  localparam logic [7:0] BDM_B1_SHARE_HI = 8'hFF;
  localparam logic [7:0] BDM_SHARE_BASE = 8'h70;     // Bank 0 target of shared window

  // ----------------------------------------------------------------
  // Status field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned BDM_ST_BANK_BIT = 5;        // bank_select_bit
  localparam int unsigned BDM_ST_RSV_UPPER = 6;       // reserved_upper_bank_bit
  localparam int unsigned BDM_ST_RSV_IND = 7;         // reserved_indirect_bank_bit
  localparam logic [7:0] BDM_RST_STATUS = 8'h18;
  localparam logic [7:0] BDM_RST_PCL = 8'h00;
  localparam logic [7:0] BDM_RST_PROGRAM_COUNTER_UPPER_LATCH = 8'h00;
  localparam logic [7:0] BDM_RST_INTCTL = 8'h00;
  localparam logic [7:0] BDM_RST_FSR = 8'h00;
  localparam logic [7:0] BDM_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Decode targets
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    BDM_T_NONE = 6'b00_0001,
    BDM_T_RAM = 6'b00_0010,
    BDM_T_STATUS = 6'b00_0100,
    BDM_T_FSR = 6'b00_1000,
    BDM_T_CORE = 6'b01_0000,
    BDM_T_SLOT = 6'b10_0000
  } bdm_target_t;

endpackage

/* File: logic/bdm_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module bdm_decoder
(
  // Full file address after bank and pointer resolution
  input wire logic [7:0] faddr,
  // Decode result
  output var bdm_pkg::bdm_target_t target,
  output logic [6:0] ram_index,
  output logic [4:0] slot_index
);
  import bdm_pkg::*;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Pure decode; the core slot numbers are checked on the low bits so both banks agree
  always_comb
  begin
    target = BDM_T_NONE;
    ram_index = 7'h00;
    slot_index = faddr[4:0];
    if (faddr[6:0] == BDM_OFS_STATUS)
    begin
      target = BDM_T_STATUS;
    end
    else if (faddr[6:0] == BDM_OFS_FSR)
    begin
      target = BDM_T_FSR;
    end
    else if (faddr[6:0] == BDM_OFS_PCL || faddr[6:0] == BDM_OFS_PROGRAM_COUNTER_UPPER_LATCH ||
             faddr[6:0] == BDM_OFS_INTCTL)
    begin
      target = BDM_T_CORE;
    end
    else if (faddr[6:0] == BDM_OFS_INDIRECT)
    begin
      target = BDM_T_NONE;
    end
    else if (faddr[6:0] < BDM_SLOT_LIMIT[6:0])
    begin
      target = BDM_T_SLOT;
      slot_index = faddr[4:0];                                // Offsets below 20h not taken by core registers; caller adds bank bit
    end
    else if (faddr >= BDM_B0_RAM_LO && faddr <= BDM_B0_RAM_HI)
    begin
      target = BDM_T_RAM;
      ram_index = 7'(faddr - BDM_B0_RAM_LO);
    end
    else if (faddr >= BDM_B1_RAM_LO && faddr <= BDM_B1_RAM_HI)
    begin
      target = BDM_T_RAM;
      ram_index = 7'(faddr - BDM_B1_RAM_LO + 8'h60);
    end
    else if (faddr >= BDM_B1_SHARE_LO)
    begin
      target = BDM_T_RAM;
      ram_index = 7'(faddr - BDM_B1_SHARE_LO + BDM_SHARE_BASE - BDM_B0_RAM_LO);
    end
    else
    begin
      target = BDM_T_NONE;
    end
  end

endmodule
`default_nettype wire

/* File: logic/bdm_map.sv */
// Function
// - 128 by 8 data register file
// - Reach by direct address or pointer
// - Slot storage is static, no refresh
// - Unimplemented reads zero, writes ignored
// - Indirect location redirects through pointer
// - Slots occupy the bank offsets below 20h not taken by core registers, 26 in each bank
// - RAM at 20h-7Fh and A0h-BFh
// - F0h-FFh share storage with 70h-7Fh
// - Bank bit selects bank; reserved kept zero
`timescale 1ns/1ps
`default_nettype none
module bdm_map
#(
  // General purpose bytes; the decode is fixed to the 128 byte file
  parameter int unsigned GP_DEPTH = 128,
  // Slot bytes, 32 offsets in each of the two banks
  parameter int unsigned SLOT_DEPTH = 64
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Core access port
  input wire logic [6:0] dir_addr,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // Answer
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Core register views
  output logic [7:0] status_q,
  output logic [7:0] pointer_q,
  output logic [7:0] pcl_q,
  output logic [7:0] program_counter_upper_latch_q,
  output logic [7:0] intctl_q,
  output logic bank_sel
);
  import bdm_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Everything that is reset lives in one struct; RAM arrays are kept apart
  typedef struct packed {
    logic [7:0] status;    // Core status byte
    logic [7:0] indirect_pointer;       // file_select_pointer
    logic [7:0] program_counter_low_byte;       // program_counter_low_byte
    logic [7:0] program_counter_upper_latch;    // program_counter_upper_latch
    logic [7:0] intctl;    // interrupt_control_flags
    logic [7:0] rdata;     // Registered read answer
    logic rvalid;          // Answer strobe
  } bdm_state_t;

  bdm_state_t cur;
  bdm_state_t next_cur;

  // Storage: 96 bank-0 plus 32 bank-1 bytes form the 128 x 8 file
  logic [7:0] gp_ram [0:GP_DEPTH-1];
  // Peripheral slot bytes, two banks of 32 offsets
  logic [7:0] slot_ram [0:SLOT_DEPTH-1];

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // The decoder hands out 7-bit file and 5-bit slot indices, 6-bit with the bank bit, so any other
  // depth would leave bytes unreachable or index past the array
  if (GP_DEPTH != 128 || SLOT_DEPTH != 64)
  begin : g_depth_check
    $error("bdm_map supports only GP_DEPTH 128 and SLOT_DEPTH 64");
  end

  logic [7:0] faddr;                       // Resolved file address
  bdm_target_t target;
  logic [6:0] ram_index;
  logic [4:0] slot_index;
  logic [5:0] slot_addr;

  // ----------------------------------------------------------------
  // Address resolution
  // ----------------------------------------------------------------
  // Indirect offset swaps in the pointer; otherwise bank bit plus direct field
  always_comb
  begin
    if (dir_addr == BDM_OFS_INDIRECT)
    begin
      faddr = cur.indirect_pointer;
    end
    else
    begin
      faddr = {cur.status[BDM_ST_BANK_BIT], dir_addr};
    end
  end

  bdm_decoder u_dec
  (
    .faddr(faddr),
    .target(target),
    .ram_index(ram_index),
    .slot_index(slot_index)
  );

  // Slot bytes are kept per bank: the resolved bank bit picks the half
  assign slot_addr = {faddr[7], slot_index};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // A pointer aimed at offset 0 finds no storage and reads zero, which
  // stops the redirection from chasing itself
  always_comb
  begin
    next_cur = cur;
    next_cur.rvalid = rd_en;
    next_cur.rdata = BDM_ZERO;
    // Read path: every target answers, unimplemented ones with zero
    if (rd_en)
    begin
      unique case (target)
        BDM_T_RAM: next_cur.rdata = gp_ram[ram_index];
        BDM_T_SLOT: next_cur.rdata = slot_ram[slot_addr];
        BDM_T_STATUS: next_cur.rdata = cur.status;
        BDM_T_FSR: next_cur.rdata = cur.indirect_pointer;
        BDM_T_CORE:
        begin
          if (faddr[6:0] == BDM_OFS_PCL)
          begin
            next_cur.rdata = cur.program_counter_low_byte;
          end
          else if (faddr[6:0] == BDM_OFS_PROGRAM_COUNTER_UPPER_LATCH)
          begin
            next_cur.rdata = cur.program_counter_upper_latch;
          end
          else
          begin
            next_cur.rdata = cur.intctl;
          end
        end
        BDM_T_NONE: next_cur.rdata = BDM_ZERO;
      endcase
    end
    // Write path: only the addressed core register moves here
    if (wr_en)
    begin
      unique case (target)
        BDM_T_STATUS:
        begin
          // Reserved bank bits are kept at zero by hardware as well
          next_cur.status = wr_data;
          next_cur.status[BDM_ST_RSV_UPPER] = 1'b0;
          next_cur.status[BDM_ST_RSV_IND] = 1'b0;
        end
        BDM_T_FSR: next_cur.indirect_pointer = wr_data;
        BDM_T_CORE:
        begin
          if (faddr[6:0] == BDM_OFS_PCL)
          begin
            next_cur.program_counter_low_byte = wr_data;
          end
          else if (faddr[6:0] == BDM_OFS_PROGRAM_COUNTER_UPPER_LATCH)
          begin
            next_cur.program_counter_upper_latch = wr_data;
          end
          else
          begin
            next_cur.intctl = wr_data;
          end
        end
        // Array writes happen in the storage process below
        BDM_T_RAM, BDM_T_SLOT, BDM_T_NONE:
        begin
          next_cur.indirect_pointer = cur.indirect_pointer;                             // Arrays or nothing
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset loads constants only; the answer stays quiet until a read
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur <= '{status: BDM_RST_STATUS, indirect_pointer: BDM_RST_FSR, program_counter_low_byte: BDM_RST_PCL,
               program_counter_upper_latch: BDM_RST_PROGRAM_COUNTER_UPPER_LATCH, intctl: BDM_RST_INTCTL,
               rdata: BDM_ZERO, rvalid: 1'b0};
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // Static arrays hold without reset or refresh; contents start unknown
  always_ff @(posedge clk)
  begin
    if (wr_en && target == BDM_T_RAM)
    begin
      gp_ram[ram_index] <= wr_data;
    end
    if (wr_en && target == BDM_T_SLOT)
    begin
      slot_ram[slot_addr] <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Views come straight from the state register, no logic after the flop
  assign rd_data = cur.rdata;
  assign rd_valid = cur.rvalid;
  assign status_q = cur.status;
  assign pointer_q = cur.indirect_pointer;
  assign pcl_q = cur.program_counter_low_byte;
  assign program_counter_upper_latch_q = cur.program_counter_upper_latch;
  assign intctl_q = cur.intctl;
  assign bank_sel = cur.status[BDM_ST_BANK_BIT];

endmodule
`default_nettype wire

/* File: dv/bdm_map_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module bdm_map_checker
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requests
  input wire logic [6:0] dir_addr,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // Answers and views
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic [7:0] status_q,
  input wire logic [7:0] pointer_q,
  input wire logic [7:0] pcl_q,
  input wire logic bank_sel
);
  // ----------------------------------------
  // Setup
  // ----------------------------------------
  // One domain, so clock and reset stated once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Write data of the previous cycle, so checks can name a bit of it
  logic [7:0] wd_q;
  always_ff @(posedge clk)
  begin
    wd_q <= wr_data;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_read_answer: assert property (rd_en |=> rd_valid)
    else $error("read not answered in the next cycle");
  a_idle_quiet: assert property (!rd_en |=> !rd_valid && rd_data == 8'h00)
    else $error("answer without a read");
  a_bank_view: assert property (bank_sel == status_q[5])
    else $error("bank select differs from status");
  a_bank_hold: assert property (!wr_en |=> $stable(bank_sel))
    else $error("bank select changed without a write");
  a_rsv_zero: assert property (status_q[7:6] == 2'b00)
    else $error("reserved bank bits set");
  a_bank_write: assert property (wr_en && dir_addr == 7'h03 |=> bank_sel == wd_q[5])
    else $error("status write lost bank bit");
  a_ptr_write: assert property (wr_en && dir_addr == 7'h04 |=> pointer_q == wd_q)
    else $error("pointer write lost");
  a_pcl_write: assert property (wr_en && dir_addr == 7'h02 |=> pcl_q == wd_q)
    else $error("counter low byte write lost");
  a_ptr_hold: assert property (!wr_en |=> $stable(pointer_q))
    else $error("pointer changed without a write");
  a_gap_zero: assert property (rd_en && bank_sel && dir_addr inside {[7'h40:7'h6F]} |=> rd_data == 8'h00)
    else $error("unimplemented place read nonzero");
  a_ind_null: assert property (rd_en && dir_addr == 7'h00 && pointer_q[6:0] == 7'h00 |=> rd_data == 8'h00)
    else $error("indirect place read nonzero");
endmodule
bind bdm_map bdm_map_checker i_bdm_map_checker (.clk(clk), .rst_n(rst_n), .dir_addr(dir_addr),
  .rd_en(rd_en), .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
  .status_q(status_q), .pointer_q(pointer_q), .pcl_q(pcl_q), .bank_sel(bank_sel));
`default_nettype wire

/* File: dv/bdm_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bdm_core_model
(
  // Clock
  input wire logic clk,
  // Requests
  output logic [6:0] dir_addr,
  output logic rd_en,
  output logic wr_en,
  output logic [7:0] wr_data,
  // Answer
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  // Idle at time zero
  initial
  begin
    dir_addr = 7'h00;
    rd_en = 1'b0;
    wr_en = 1'b0;
    wr_data = 8'h00;
  end
  // One write cycle; data inverted after, so stale data is never read back
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
  begin
    @(negedge clk);
    dir_addr = a;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
    wr_data = ~d;
  end
  endtask
  // One read; the answer stands from the taking edge and is sampled half a cycle later
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
  begin
    @(negedge clk);
    dir_addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    ok = rd_valid;
    d = rd_data;
  end
  endtask
endmodule
`default_nettype wire

/* File: dv/bdm_map_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module bdm_map_tb;
  import bdm_pkg::*;
  // Clock, reset and wires
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] dir_addr;
  logic rd_en, wr_en, rd_valid, bank_sel, ok;
  logic [7:0] wr_data, rd_data, status_q, pointer_q, pcl_q, program_counter_upper_latch_q, intctl_q;
  int err_count = 0;
  int n_compared = 0;
  always #2 clk = ~clk;
  bdm_map i_bdm_map (.clk(clk), .rst_n(rst_n), .dir_addr(dir_addr), .rd_en(rd_en), .wr_en(wr_en),
    .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .status_q(status_q),
    .pointer_q(pointer_q), .pcl_q(pcl_q), .program_counter_upper_latch_q(program_counter_upper_latch_q), .intctl_q(intctl_q), .bank_sel(bank_sel));
  bdm_core_model i_bdm_core_model (.clk(clk), .dir_addr(dir_addr), .rd_en(rd_en), .wr_en(wr_en),
    .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));
  // Byte compare
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
  begin
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  // Read and compare, answer flag included
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
  begin
    i_bdm_core_model.rd(a, d, ok);
    cmp({7'h00, ok}, 8'h01);
    cmp(d, exp);
  end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
  begin
    i_bdm_core_model.wr(a, d);
  end
  endtask
  task automatic end_of_test;
  begin
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  // Hang guard
  initial
  begin
    repeat (2000) @(posedge clk);
    err_count++;
    end_of_test;
  end
  // Main sequence
  initial
  begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    cmp(status_q, BDM_RST_STATUS);
    cmp(pointer_q, BDM_RST_FSR);
    wr(7'h20, 8'h11);
    wr(7'h70, 8'h33);
    wr(7'h0C, 8'hC3);
    wr(7'h1C, 8'h5D);
    wr(7'h04, 8'hA0);
    wr(7'h00, 8'h44);
    wr(7'h03, 8'hE0);
    cmp({7'h00, bank_sel}, 8'h01);
    cmp({6'h00, status_q[7:6]}, 8'h00);
    wr(7'h0C, 8'hB4);
    rchk(7'h20, 8'h44);
    rchk(7'h70, 8'h33);
    wr(7'h7F, 8'h55);
    wr(7'h3F, 8'h66);
    wr(7'h40, 8'h77);
    rchk(7'h40, 8'h00);
    rchk(7'h3F, 8'h66);
    rchk(7'h04, 8'hA0);
    wr(7'h04, 8'h80);
    wr(7'h00, 8'h99);
    rchk(7'h00, 8'h00);
    wr(7'h04, 8'h25);
    wr(7'h00, 8'h5A);
    wr(7'h02, 8'h3C);
    wr(7'h0A, 8'h15);
    wr(7'h0B, 8'h81);
    wr(7'h03, 8'h00);
    cmp(status_q, 8'h00);
    cmp(pcl_q, 8'h3C);
    cmp(program_counter_upper_latch_q, 8'h15);
    cmp(intctl_q, 8'h81);
    rchk(7'h02, 8'h3C);
    rchk(7'h0A, 8'h15);
    rchk(7'h0B, 8'h81);
    rchk(7'h20, 8'h11);
    rchk(7'h7F, 8'h55);
    rchk(7'h25, 8'h5A);
    rchk(7'h0C, 8'hC3);
    rchk(7'h1C, 8'h5D);
    wr(7'h03, 8'h20);
    rchk(7'h0C, 8'hB4);
    end_of_test;
  end
endmodule
`default_nettype wire
